// *** hw/sgc_pkg.sv ***
// constants shared by the switch global configuration register slice
package sgc_pkg;

    // *****************************************************************
    // bus geometry
    // *****************************************************************
    localparam int unsigned IDX_W  = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SEL_W  = 4;
    localparam int unsigned BYTE_W = 8;

    // *****************************************************************
    // register indices (byte address is four times the index)
    // *****************************************************************
    localparam logic [IDX_W-1:0] IDX_MAC3 = 10'h305;
    localparam logic [IDX_W-1:0] IDX_MAC4 = 10'h306;
    localparam logic [IDX_W-1:0] IDX_MAC5 = 10'h307;
    localparam logic [IDX_W-1:0] IDX_MTU  = 10'h308;
    localparam logic [IDX_W-1:0] IDX_TPID = 10'h30a;
    localparam logic [IDX_W-1:0] IDX_CBS  = 10'h30e;
    localparam logic [IDX_W-1:0] IDX_LUC0 = 10'h310;

    // *****************************************************************
    // field layout
    // *****************************************************************
    localparam int unsigned MTU_W       = 14;
    localparam int unsigned TPID_W      = 16;
    localparam int unsigned CBS_SHP     = 1;
    localparam int unsigned CBS_POL     = 0;
    localparam int unsigned LUC_VLAN    = 7;
    localparam int unsigned LUC_DROP    = 6;
    localparam int unsigned LUC_AGE_LSB = 3;
    localparam int unsigned AGE_W       = 3;
    localparam int unsigned LUC_RSVD    = 2;
    localparam int unsigned LUC_HASH    = 0;
    localparam int unsigned HASH_SEL_W  = 2;

    // *****************************************************************
    // reset values and the jumbo mtu value
    // *****************************************************************
    localparam logic [BYTE_W-1:0]     MAC3_RST  = 8'hff;
    localparam logic [BYTE_W-1:0]     MAC4_RST  = 8'hff;
    localparam logic [BYTE_W-1:0]     MAC5_RST  = 8'hff;
    localparam logic [MTU_W-1:0]      MTU_RST   = 14'h07d0;
    localparam logic [MTU_W-1:0]      MTU_JUMBO = 14'h2328;
    localparam logic [TPID_W-1:0]     TPID_RST  = 16'h9100;
    localparam logic                  SHP_RST   = 1'b1;
    localparam logic                  POL_RST   = 1'b1;
    localparam logic                  VLAN_RST  = 1'b0;
    localparam logic                  DROP_RST  = 1'b1;
    localparam logic [AGE_W-1:0]      AGE_RST   = 3'h4;
    localparam logic                  RSVD_RST  = 1'b0;
    localparam logic [HASH_SEL_W-1:0] HASH_RST  = 2'h1;

    // *****************************************************************
    // lookup hashing
    // *****************************************************************
    localparam logic [HASH_SEL_W-1:0] HASH_DIR0 = 2'h0;
    localparam logic [HASH_SEL_W-1:0] HASH_CRC  = 2'h1;
    localparam logic [HASH_SEL_W-1:0] HASH_XOR  = 2'h2;
    localparam logic [HASH_SEL_W-1:0] HASH_DIR3 = 2'h3;
    localparam int unsigned           HASH_W    = 10;
    localparam int unsigned           ADDR_W    = 48;
    localparam int unsigned           FOLD_N    = 5;
    localparam logic [HASH_W-1:0]     HASH_POLY = 10'h233;
    localparam logic [HASH_W-1:0]     HASH_INIT = 10'h3ff;

    // *****************************************************************
    // credit accounting
    // *****************************************************************
    localparam int unsigned       CHG_W     = 15;
    localparam logic [CHG_W-1:0]  IPG_BYTES = 15'h000c;
    localparam logic [CHG_W-1:0]  PRE_BYTES = 15'h0008;

endpackage : sgc_pkg

// *** hw/sgc_regs.sv ***
// switch global configuration register slice with wishbone slave
`timescale 1ns/1ps
`default_nettype none

module sgc_regs (
    // clock and reset
    input  wire  logic                          clk_i,
    input  wire  logic                          rst_i,
    // wishbone slave
    input  wire  logic                          wb_cyc_i,
    input  wire  logic                          wb_stb_i,
    input  wire  logic                          wb_we_i,
    input  wire  logic [11:2]                   wb_adr_i,
    input  wire  logic [sgc_pkg::SEL_W-1:0]     wb_sel_i,
    input  wire  logic [sgc_pkg::DATA_W-1:0]    wb_dat_i,
    output logic       [sgc_pkg::DATA_W-1:0]    wb_dat_o,
    output logic                                wb_ack_o,
    // switch address: upper bytes from the neighbouring bank
    input  wire  logic [23:0]                   mac_addr_hi_i,
    output logic       [sgc_pkg::ADDR_W-1:0]    pause_src_addr_o,
    input  wire  logic                          rx_sa_valid_i,
    input  wire  logic [sgc_pkg::ADDR_W-1:0]    rx_sa_i,
    output logic                                self_addr_match_o,
    // frame length check and credit charge
    input  wire  logic                          frame_len_valid_i,
    input  wire  logic [sgc_pkg::MTU_W-1:0]     frame_len_i,
    output logic                                frame_truncate_o,
    output logic       [sgc_pkg::MTU_W-1:0]     max_frame_len_o,
    output logic       [sgc_pkg::CHG_W-1:0]     shaper_charge_o,
    output logic       [sgc_pkg::CHG_W-1:0]     police_charge_o,
    // tagging
    output logic       [sgc_pkg::TPID_W-1:0]    provider_outer_tag_o,
    // vlan handling
    output logic                                vlan_enable_o,
    input  wire  logic                          vid_check_i,
    input  wire  logic                          vid_invalid_i,
    input  wire  logic                          unknown_vid_fwd_i,
    output logic                                vid_drop_o,
    output logic                                vid_to_host_o,
    // address table
    input  wire  logic                          entry_update_i,
    output logic                                age_load_o,
    output logic       [sgc_pkg::AGE_W-1:0]     age_load_val_o,
    output logic                                rsvd_mcast_en_o,
    input  wire  logic                          lookup_req_i,
    input  wire  logic [sgc_pkg::ADDR_W-1:0]    lookup_da_i,
    output logic                                lookup_idx_valid_o,
    output logic       [sgc_pkg::HASH_W-1:0]    lookup_idx_o
);
    import sgc_pkg::*;

    // *****************************************************************
    // state
    // *****************************************************************
    typedef struct packed {
        logic                  ack;
        logic [DATA_W-1:0]     rdata;
        logic [BYTE_W-1:0]     mac3;
        logic [BYTE_W-1:0]     mac4;
        logic [BYTE_W-1:0]     mac5;
        logic [MTU_W-1:0]      mtu;
        logic [TPID_W-1:0]     tpid;
        logic                  shp_ipg;
        logic                  pol_ipg;
        logic                  vlan_en;
        logic                  drop_inv;
        logic [AGE_W-1:0]      age;
        logic                  rsvd_mc;
        logic [HASH_SEL_W-1:0] lookup_hash_select;
        logic [ADDR_W-1:0]     pause_sa;
        logic                  self_match;
        logic                  trunc;
        logic [CHG_W-1:0]      shp_chg;
        logic [CHG_W-1:0]      pol_chg;
        logic                  vid_drop;
        logic                  vid_host;
        logic                  age_load;
        logic [AGE_W-1:0]      age_val;
        logic                  idx_valid;
        logic [HASH_W-1:0]     idx;
    } sgc_state_s;

    sgc_state_s s_q;
    sgc_state_s s_d;

    // *****************************************************************
    // hash functions
    // *****************************************************************
    function automatic logic [HASH_W-1:0] crc_hash(
        input logic [ADDR_W-1:0] a
    );
        logic [HASH_W-1:0] c;
        logic              fb;
        c = HASH_INIT;
        for (int i = ADDR_W - 1; i >= 0; i--) begin
            fb = c[HASH_W-1] ^ a[i];
            c  = {c[HASH_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ HASH_POLY;
            end
        end
        return c;
    endfunction : crc_hash

    function automatic logic [HASH_W-1:0] xor_hash(
        input logic [ADDR_W-1:0] a
    );
        logic [HASH_W-1:0] r;
        r = '0;
        for (int i = 0; i < FOLD_N; i++) begin
            r = r ^ HASH_W'(a >> (i * HASH_W));
        end
        return r;
    endfunction : xor_hash

    // *****************************************************************
    // bus decode
    // *****************************************************************
    logic req;
    logic wr;
    logic lo_en;
    logic hi_en;

    assign req   = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign wr    = req & wb_we_i;
    assign lo_en = wb_sel_i[0];
    assign hi_en = wb_sel_i[1];

    // *****************************************************************
    // next state
    // *****************************************************************
    always_comb begin
        s_d = s_q;

        // single-wait answer; ack drops in the cycle after it is given
        s_d.ack   = req;
        s_d.rdata = '0;

        // register writes, per byte lane
        if (wr) begin
            case (wb_adr_i)
                IDX_MAC3: begin
                    if (lo_en) begin
                        s_d.mac3 = wb_dat_i[BYTE_W-1:0];
                    end
                end
                IDX_MAC4: begin
                    if (lo_en) begin
                        s_d.mac4 = wb_dat_i[BYTE_W-1:0];
                    end
                end
                IDX_MAC5: begin
                    if (lo_en) begin
                        s_d.mac5 = wb_dat_i[BYTE_W-1:0];
                    end
                end
                IDX_MTU: begin
                    // full 14-bit range, jumbo values included
                    if (lo_en) begin
                        s_d.mtu[BYTE_W-1:0] = wb_dat_i[BYTE_W-1:0];
                    end
                    if (hi_en) begin
                        s_d.mtu[MTU_W-1:BYTE_W] =
                            wb_dat_i[MTU_W-1:BYTE_W];
                    end
                end
                IDX_TPID: begin
                    if (lo_en) begin
                        s_d.tpid[BYTE_W-1:0] = wb_dat_i[BYTE_W-1:0];
                    end
                    if (hi_en) begin
                        s_d.tpid[TPID_W-1:BYTE_W] =
                            wb_dat_i[TPID_W-1:BYTE_W];
                    end
                end
                IDX_CBS: begin
                    if (lo_en) begin
                        s_d.shp_ipg = wb_dat_i[CBS_SHP];
                        s_d.pol_ipg = wb_dat_i[CBS_POL];
                    end
                end
                IDX_LUC0: begin
                    if (lo_en) begin
                        s_d.vlan_en  = wb_dat_i[LUC_VLAN];
                        s_d.drop_inv = wb_dat_i[LUC_DROP];
                        s_d.age      =
                            wb_dat_i[LUC_AGE_LSB +: AGE_W];
                        s_d.rsvd_mc  = wb_dat_i[LUC_RSVD];
                        s_d.lookup_hash_select =
                            wb_dat_i[LUC_HASH +: HASH_SEL_W];
                    end
                end
                default: begin
                    s_d.ack = req;
                end
            endcase
        end

        // read data, reserved and unmapped bits as zero
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                IDX_MAC3: s_d.rdata[BYTE_W-1:0] = s_q.mac3;
                IDX_MAC4: s_d.rdata[BYTE_W-1:0] = s_q.mac4;
                IDX_MAC5: s_d.rdata[BYTE_W-1:0] = s_q.mac5;
                IDX_MTU:  s_d.rdata[MTU_W-1:0]  = s_q.mtu;
                IDX_TPID: s_d.rdata[TPID_W-1:0] = s_q.tpid;
                IDX_CBS: begin
                    s_d.rdata[CBS_SHP] = s_q.shp_ipg;
                    s_d.rdata[CBS_POL] = s_q.pol_ipg;
                end
                IDX_LUC0: begin
                    s_d.rdata[LUC_VLAN]              = s_q.vlan_en;
                    s_d.rdata[LUC_DROP]              = s_q.drop_inv;
                    s_d.rdata[LUC_AGE_LSB +: AGE_W]  = s_q.age;
                    s_d.rdata[LUC_RSVD]              = s_q.rsvd_mc;
                    s_d.rdata[LUC_HASH +: HASH_SEL_W] =
                        s_q.lookup_hash_select;
                end
                default: s_d.rdata = '0;
            endcase
        end

        // *************************************************************
        // switch address use
        // *************************************************************
        s_d.pause_sa   = {mac_addr_hi_i, s_q.mac3, s_q.mac4,
                          s_q.mac5};
        s_d.self_match = rx_sa_valid_i &&
                         (rx_sa_i == s_q.pause_sa);

        // *************************************************************
        // length check and credit charge
        // *************************************************************
        s_d.trunc = frame_len_valid_i &&
                    (frame_len_i > s_q.mtu);
        s_d.shp_chg = CHG_W'(frame_len_i);
        s_d.pol_chg = CHG_W'(frame_len_i);
        if (s_q.shp_ipg) begin
            s_d.shp_chg = CHG_W'(frame_len_i) + IPG_BYTES +
                          PRE_BYTES;
        end
        if (s_q.pol_ipg) begin
            s_d.pol_chg = CHG_W'(frame_len_i) + IPG_BYTES +
                          PRE_BYTES;
        end

        // *************************************************************
        // vlan id handling
        // *************************************************************
        s_d.vid_drop = vid_check_i && vid_invalid_i &&
                       !unknown_vid_fwd_i && s_q.drop_inv;
        s_d.vid_host = vid_check_i && vid_invalid_i &&
                       !unknown_vid_fwd_i && !s_q.drop_inv;

        // *************************************************************
        // address table aging and indexing
        // *************************************************************
        s_d.age_load = entry_update_i;
        if (entry_update_i) begin
            s_d.age_val = s_q.age;
        end

        s_d.idx_valid = lookup_req_i;
        if (lookup_req_i) begin
            case (s_q.lookup_hash_select)
                HASH_CRC: s_d.idx = crc_hash(lookup_da_i);
                HASH_XOR: s_d.idx = xor_hash(lookup_da_i);
                HASH_DIR0,
                HASH_DIR3: s_d.idx = lookup_da_i[HASH_W-1:0];
                default: s_d.idx = lookup_da_i[HASH_W-1:0];
            endcase
        end

        // *************************************************************
        // reset
        // *************************************************************
        if (rst_i) begin
            s_d                    = '0;
            s_d.mac3               = MAC3_RST;
            s_d.mac4               = MAC4_RST;
            s_d.mac5               = MAC5_RST;
            s_d.mtu                = MTU_RST;
            s_d.tpid               = TPID_RST;
            s_d.shp_ipg            = SHP_RST;
            s_d.pol_ipg            = POL_RST;
            s_d.vlan_en            = VLAN_RST;
            s_d.drop_inv           = DROP_RST;
            s_d.age                = AGE_RST;
            s_d.age_val            = AGE_RST;
            s_d.rsvd_mc            = RSVD_RST;
            s_d.lookup_hash_select = HASH_RST;
        end
    end

    // *****************************************************************
    // state register
    // *****************************************************************
    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    // *****************************************************************
    // outputs
    // *****************************************************************
    assign wb_ack_o             = s_q.ack;
    assign wb_dat_o             = s_q.rdata;
    assign pause_src_addr_o     = s_q.pause_sa;
    assign self_addr_match_o    = s_q.self_match;
    assign frame_truncate_o     = s_q.trunc;
    assign max_frame_len_o      = s_q.mtu;
    assign shaper_charge_o      = s_q.shp_chg;
    assign police_charge_o      = s_q.pol_chg;
    assign provider_outer_tag_o = s_q.tpid;
    assign vlan_enable_o        = s_q.vlan_en;
    assign vid_drop_o           = s_q.vid_drop;
    assign vid_to_host_o        = s_q.vid_host;
    assign age_load_o           = s_q.age_load;
    assign age_load_val_o       = s_q.age_val;
    assign rsvd_mcast_en_o      = s_q.rsvd_mc;
    assign lookup_idx_valid_o   = s_q.idx_valid;
    assign lookup_idx_o         = s_q.idx;

endmodule : sgc_regs

`default_nettype wire

// *** test/sgc_regs_asserts.sv ***
// concurrent checks on the ports of the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module sgc_regs_asserts
    import sgc_pkg::*;
(
    // clock, reset and bus
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic [sgc_pkg::DATA_W-1:0] wb_dat_o,
    input wire logic                       wb_ack_o,
    // address and frame side
    input wire logic [23:0]                mac_addr_hi_i,
    input wire logic [sgc_pkg::ADDR_W-1:0] pause_src_addr_o,
    input wire logic                       rx_sa_valid_i,
    input wire logic [sgc_pkg::ADDR_W-1:0] rx_sa_i,
    input wire logic                       self_addr_match_o,
    input wire logic                       frame_len_valid_i,
    input wire logic [sgc_pkg::MTU_W-1:0]  frame_len_i,
    input wire logic                       frame_truncate_o,
    input wire logic [sgc_pkg::MTU_W-1:0]  max_frame_len_o,
    input wire logic [sgc_pkg::CHG_W-1:0]  shaper_charge_o,
    input wire logic [sgc_pkg::CHG_W-1:0]  police_charge_o,
    // vlan and lookup side
    input wire logic                       vid_check_i,
    input wire logic                       vid_invalid_i,
    input wire logic                       unknown_vid_fwd_i,
    input wire logic                       vid_drop_o,
    input wire logic                       vid_to_host_o,
    input wire logic                       entry_update_i,
    input wire logic                       age_load_o,
    input wire logic                       lookup_req_i,
    input wire logic [sgc_pkg::HASH_W-1:0] lookup_idx_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack;
        s_req |=> s_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer wrong");
    property p_rd0;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("idle read data");
    property p_trunc;
        frame_len_valid_i |=>
            frame_truncate_o == ($past(frame_len_i) > $past(max_frame_len_o));
    endproperty
    a_trunc: assert property (p_trunc) else $error("truncate flag");
    property p_jumbo;
        frame_len_valid_i && frame_len_i <= MTU_JUMBO
            && max_frame_len_o == MTU_JUMBO |=> !frame_truncate_o;
    endproperty
    a_jumbo: assert property (p_jumbo) else $error("jumbo cut");
    property p_shp;
        frame_len_valid_i |=> shaper_charge_o == {1'b0, $past(frame_len_i)}
            || shaper_charge_o == {1'b0, $past(frame_len_i)} + 15'h0014;
    endproperty
    a_shp: assert property (p_shp) else $error("shaper charge");
    property p_pol;
        frame_len_valid_i |=> police_charge_o == {1'b0, $past(frame_len_i)}
            || police_charge_o == {1'b0, $past(frame_len_i)} + 15'h0014;
    endproperty
    a_pol: assert property (p_pol) else $error("police charge");
    property p_drop;
        vid_check_i && vid_invalid_i && !unknown_vid_fwd_i
            |=> vid_drop_o != vid_to_host_o;
    endproperty
    a_drop: assert property (p_drop) else $error("invalid vid");
    property p_unk;
        vid_check_i && unknown_vid_fwd_i |=> !vid_drop_o && !vid_to_host_o;
    endproperty
    a_unk: assert property (p_unk) else $error("unknown vid");
    property p_age;
        !$past(rst_i) |-> age_load_o == $past(entry_update_i);
    endproperty
    a_age: assert property (p_age) else $error("age load pulse");
    property p_idx;
        !lookup_req_i |=> $stable(lookup_idx_o);
    endproperty
    a_idx: assert property (p_idx) else $error("index moved");
    property p_self;
        rx_sa_valid_i |=> self_addr_match_o
            == ($past(rx_sa_i) == $past(pause_src_addr_o));
    endproperty
    a_self: assert property (p_self) else $error("self match");
    property p_pause;
        !$past(rst_i) |-> pause_src_addr_o[47:24] == $past(mac_addr_hi_i);
    endproperty
    a_pause: assert property (p_pause) else $error("pause source");
endmodule : sgc_regs_asserts
bind sgc_regs sgc_regs_asserts chk_u (.*);
`default_nettype wire

// *** test/test_sgc_regs.sv ***
// self-checking bench for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module test_sgc_regs;
    import sgc_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_ack_o;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:2] wb_adr_i = '0;
    logic [3:0]  wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, q;
    logic        self_addr_match_o, frame_truncate_o, vlan_enable_o;
    logic        vid_drop_o, vid_to_host_o, age_load_o, rsvd_mcast_en_o;
    logic        lookup_idx_valid_o, rx_sa_valid_i = 1'b0;
    logic        frame_len_valid_i = 1'b0, vid_check_i = 1'b0;
    logic        vid_invalid_i = 1'b0, unknown_vid_fwd_i = 1'b0;
    logic        entry_update_i = 1'b0, lookup_req_i = 1'b0;
    logic [23:0] mac_addr_hi_i = 24'h0a0b0c;
    logic [47:0] pause_src_addr_o, rx_sa_i = '0, lookup_da_i = '0;
    logic [13:0] frame_len_i = '0, max_frame_len_o;
    logic [14:0] shaper_charge_o, police_charge_o;
    logic [15:0] provider_outer_tag_o;
    logic [2:0]  age_load_val_o;
    logic [9:0]  lookup_idx_o;
    int          n_fail = 0, tests_run = 0, cycles = 0;
    sgc_regs dut_u (.*);
    always #20 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [63:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [9:0] a, input logic [3:0] s,
                        input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
        // no cycle limit here: only the bench timeout ends a hung wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : xfer
    // one cycle of every side strobe, outputs judged at the next low phase
    task automatic strobe(input logic [47:0] da, input logic [13:0] len,
                          input logic [47:0] sa, input logic inv, unk);
        @(posedge clk_i);
        {lookup_da_i, frame_len_i, rx_sa_i} <= {da, len, sa};
        {vid_invalid_i, unknown_vid_fwd_i} <= {inv, unk};
        {lookup_req_i, entry_update_i, vid_check_i} <= 3'h7;
        {frame_len_valid_i, rx_sa_valid_i} <= 2'h3;
        @(posedge clk_i);
        {lookup_req_i, entry_update_i, vid_check_i} <= 3'h0;
        {frame_len_valid_i, rx_sa_valid_i} <= 2'h0;
        @(negedge clk_i);
    endtask : strobe
    function automatic logic [9:0] exp_idx(input logic [1:0] h,
                                           input logic [47:0] a);
        logic [9:0] c;
        c = a[9:0];
        if (h == HASH_XOR)
            c = c ^ a[19:10] ^ a[29:20] ^ a[39:30] ^ {2'h0, a[47:40]};
        if (h == HASH_CRC) begin
            c = HASH_INIT;
            for (int i = 47; i >= 0; i--)
                c = {c[8:0], 1'b0} ^ ((c[9] ^ a[i]) ? HASH_POLY : 10'h0);
        end
        return c;
    endfunction : exp_idx
    task automatic t_regs();
        logic [9:0]  ix [7] = '{IDX_MAC3, IDX_MAC4, IDX_MAC5, IDX_MTU, IDX_TPID,
                                IDX_CBS, IDX_LUC0};
        logic [31:0] rv [7] = '{32'hff, 32'hff, 32'hff, 32'h7d0, 32'h9100,
                                32'h3, 32'h61};
        logic [31:0] mk [7] = '{32'hff, 32'hff, 32'hff, 32'h3fff, 32'hffff,
                                32'h3, 32'hff};
        chk("tag out", TPID_RST, provider_outer_tag_o);
        chk("max len out", MTU_RST, max_frame_len_o);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, ix[i], 4'h0, '0);
            chk("reset value", rv[i], q);
            xfer(1'b1, ix[i], 4'hf, 32'hffff_ffff);
            xfer(1'b0, ix[i], 4'h0, '0);
            chk("ones read back", mk[i], q);
            xfer(1'b1, ix[i], 4'hf, rv[i]);
        end
        xfer(1'b0, 10'h309, 4'h0, '0);
        chk("unmapped read", 32'h0, q);
    endtask : t_regs
    task automatic t_len();
        xfer(1'b1, IDX_MTU, 4'h3, 32'h2328);
        chk("max len out", MTU_JUMBO, max_frame_len_o);
        strobe('0, 14'h2328, '0, 1'b0, 1'b0);
        chk("truncate", 1'b0, frame_truncate_o);
        strobe('0, 14'h2329, '0, 1'b0, 1'b0);
        chk("truncate", 1'b1, frame_truncate_o);
        xfer(1'b1, IDX_MTU, 4'h3, 32'h7d0);
        strobe('0, 14'h07d0, '0, 1'b0, 1'b0);
        chk("truncate", 1'b0, frame_truncate_o);
        strobe('0, 14'h07d1, '0, 1'b0, 1'b0);
        chk("truncate", 1'b1, frame_truncate_o);
    endtask : t_len
    task automatic t_cbs();
        for (int v = 0; v < 4; v++) begin
            xfer(1'b1, IDX_CBS, 4'h1, 32'(v));
            strobe('0, 14'h0064, '0, 1'b0, 1'b0);
            chk("shaper charge", v[1] ? 15'h78 : 15'h64, shaper_charge_o);
            chk("police charge", v[0] ? 15'h78 : 15'h64, police_charge_o);
        end
    endtask : t_cbs
    task automatic t_luc();
        logic [47:0] da = 48'h1234_5678_9abc;
        for (int h = 0; h < 4; h++) begin
            // vlan on (table taken as loaded), drop off, age 5, rsvd mcast on
            xfer(1'b1, IDX_LUC0, 4'h1, 32'hac | 32'(h));
            strobe(da, '0, '0, 1'b1, 1'(h[0]));
            chk("vlan enable", 1'b1, vlan_enable_o);
            chk("rsvd mcast", 1'b1, rsvd_mcast_en_o);
            chk("age value", 3'h5, age_load_val_o);
            chk("index", exp_idx(2'(h), da), lookup_idx_o);
            chk("to host", !h[0], vid_to_host_o);
            chk("drop", 1'b0, vid_drop_o);
        end
        xfer(1'b1, IDX_LUC0, 4'h1, 32'h61);
        strobe(da, '0, '0, 1'b1, 1'b0);
        chk("drop", 1'b1, vid_drop_o);
        chk("vlan enable", 1'b0, vlan_enable_o);
        chk("age pulse", 1'b1, age_load_o);
        chk("age value", AGE_RST, age_load_val_o);
        chk("index valid", 1'b1, lookup_idx_valid_o);
        chk("index", exp_idx(HASH_CRC, da), lookup_idx_o);
    endtask : t_luc
    task automatic t_mac();
        xfer(1'b1, IDX_MAC3, 4'h1, 32'h12);
        xfer(1'b1, IDX_MAC4, 4'h1, 32'h34);
        xfer(1'b1, IDX_MAC5, 4'h1, 32'h56);
        xfer(1'b1, IDX_MAC5, 4'h0, 32'h99);
        xfer(1'b1, IDX_TPID, 4'h2, 32'h8800);
        chk("tag out", 16'h8800, provider_outer_tag_o);
        strobe('0, '0, 48'h0a0b0c123456, 1'b0, 1'b0);
        chk("pause source", 48'h0a0b0c123456, pause_src_addr_o);
        chk("self match", 1'b1, self_addr_match_o);
        strobe('0, '0, 48'h0a0b0c123457, 1'b0, 1'b0);
        chk("self match", 1'b0, self_addr_match_o);
    endtask : t_mac
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_len();
        t_cbs();
        t_luc();
        t_mac();
        results();
    end
endmodule : test_sgc_regs
`default_nettype wire
